// file: lcr_cfg_top.sv
// configuration registers, gray store and scrambled pwm of a 16-channel sink driver
// assumes serial link signals change on the controller side of shift_clock;
// grayscale_clock is far slower than clk_sys and is sampled as a pin
`timescale 1ns/10ps
`default_nettype none
module lcr_cfg_top
    import lcr_pkg::*;
(
    // system clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // serial link
    input wire logic shift_clock,
    input wire logic serial_data_in,
    input wire logic latch_strobe,
    output logic serial_data_out,
    // pwm timing pin
    input wire logic grayscale_clock,
    // outputs and line select
    output logic [CH_N-1:0] current_sink_outputs_b,
    output logic [LINE_W-1:0] scan_line,
    // analog settings
    output logic [2:0] dark_stage_on,
    output logic [2:0] display_stage_on,
    output logic [14:0] dark_levels,
    output logic [14:0] display_levels,
    output logic [DET_W-1:0] open_detect_level,
    output logic [LVL_W-1:0] precharge_level,
    output logic precharge_on,
    output logic [15:0] sixth_register_gate_out
);
    // ----------------------------------------
    // link domain
    // ----------------------------------------
    logic [15:0] shreg;
    logic [15:0] cap_word;
    logic [CNT_W-1:0] cap_cnt;
    logic latch_d;
    logic rb_tog_l;
    logic rb_seen;
    logic [15:0] rb_word;
    logic rb_tog;

    lcr_sync #(.W(1)) u_rb_sync (
        .clk(shift_clock),
        .rst_b(rst_b),
        .d(rb_tog),
        .q(rb_tog_l)
    );

    // shift in, pass out at the far end
    always_ff @(posedge shift_clock or negedge rst_b) begin
        if (!rst_b) begin
            shreg <= '0;
            rb_seen <= 1'b0;
        end else begin
            rb_seen <= rb_tog_l;
            if (rb_tog_l != rb_seen) begin
                shreg <= rb_word;
            end else begin
                shreg <= {shreg[14:0], serial_data_in};
            end
        end
    end

    assign serial_data_out = shreg[15];

    always_ff @(posedge shift_clock or negedge rst_b) begin
        if (!rst_b) begin
            latch_d <= 1'b0;
            cap_cnt <= '0;
            cap_word <= '0;
        end else begin
            latch_d <= latch_strobe;
            if (latch_strobe && !latch_d) begin
                cap_cnt <= 4'h1;
                cap_word <= {shreg[14:0], serial_data_in};
            end else if (latch_strobe && cap_cnt != 4'hf) begin
                cap_cnt <= cap_cnt + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // command pickup in the system domain
    // ----------------------------------------
    // word and count stay still while latch is low, so the synced fall is a safe sample point
    logic latch_s;
    logic latch_s_d;
    logic cmd_go;
    logic grayscale_clock_s;
    logic grayscale_clock_d;
    logic gtick;

    lcr_sync #(.W(2)) u_in_sync (
        .clk(clk_sys),
        .rst_b(rst_b),
        .d({latch_strobe, grayscale_clock}),
        .q({latch_s, grayscale_clock_s})
    );

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            latch_s_d <= 1'b0;
            grayscale_clock_d <= 1'b0;
        end else begin
            latch_s_d <= latch_s;
            grayscale_clock_d <= grayscale_clock_s;
        end
    end

    assign cmd_go = latch_s_d && !latch_s;
    assign gtick = grayscale_clock_s && !grayscale_clock_d;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    logic [15:0] cfg [REG_N];
    logic [3:0] wr_off;
    logic [3:0] rd_off;
    logic wr_hit;
    logic rd_hit;

    assign wr_off = cap_cnt - CMD_WR_BASE;
    assign rd_off = cap_cnt - CMD_RD_BASE;
    assign wr_hit = cmd_go && cap_cnt >= CMD_WR_BASE && cap_cnt < CMD_WR_BASE + CMD_SPAN;
    assign rd_hit = cmd_go && cap_cnt >= CMD_RD_BASE && cap_cnt < CMD_RD_BASE + CMD_SPAN;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg[IDX_CFG1] <= CFG1_RST;
            cfg[IDX_DARK] <= COMP_RST;
            cfg[IDX_DISP] <= COMP_RST;
            cfg[IDX_DETP] <= DETP_RST;
            cfg[IDX_SPARE] <= SPARE_RST;
        end else if (wr_hit) begin
            cfg[wr_off[2:0]] <= cap_word;
        end
    end

    // readback word goes out through the shift register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rb_word <= '0;
            rb_tog <= 1'b0;
        end else if (rd_hit) begin
            rb_word <= cfg[rd_off[2:0]];
            rb_tog <= !rb_tog;
        end
    end

    // ----------------------------------------
    // analog setting outputs
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dark_stage_on <= '0;
            display_stage_on <= '0;
            dark_levels <= '0;
            display_levels <= '0;
            open_detect_level <= '0;
            precharge_level <= '0;
            precharge_on <= 1'b0;
            sixth_register_gate_out <= '0;
        end else begin
            dark_levels <= cfg[IDX_DARK][14:0];
            dark_stage_on <= {3{cfg[IDX_DARK][EN_BIT]}} & {
                |cfg[IDX_DARK][LVL_HI +: LVL_W],
                |cfg[IDX_DARK][LVL_MID +: LVL_W],
                |cfg[IDX_DARK][LVL_LO +: LVL_W]};
            display_levels <= cfg[IDX_DISP][14:0];
            display_stage_on <= {3{cfg[IDX_DISP][EN_BIT]}} & {
                |cfg[IDX_DISP][LVL_HI +: LVL_W],
                |cfg[IDX_DISP][LVL_MID +: LVL_W],
                |cfg[IDX_DISP][LVL_LO +: LVL_W]};
            open_detect_level <= cfg[IDX_DETP][DET_LSB +: DET_W];
            precharge_level <= cfg[IDX_DETP][PRE_LSB +: LVL_W];
            precharge_on <= |cfg[IDX_DETP][PRE_LSB +: LVL_W];
            // sixth register used only when gated on
            sixth_register_gate_out <= cfg[IDX_DETP][GATE_BIT] ? cfg[IDX_SPARE] : SPARE_RST;
        end
    end

    // ----------------------------------------
    // gray store
    // ----------------------------------------
    logic [15:0] gray_mem [MAX_LINES][CH_N];
    logic [3:0] wr_ch;
    logic [LINE_W-1:0] wr_line;
    logic [LINE_W-1:0] scan_code;

    assign scan_code = cfg[IDX_CFG1][SCAN_LSB +: LINE_W];

    // lines wrap at code, code 0 is one line
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ch <= '0;
            wr_line <= '0;
        end else if (cmd_go && cap_cnt == CMD_GRAY) begin
            wr_ch <= wr_ch + 4'h1;
            if (wr_ch == 4'hf) begin
                wr_line <= (wr_line >= scan_code) ? '0 : wr_line + 5'h1;
            end
        end
    end

    // gray words are not reset; lines are expected to be loaded before display
    always_ff @(posedge clk_sys) begin
        if (cmd_go && cap_cnt == CMD_GRAY) begin
            gray_mem[wr_line][wr_ch] <= cap_word;
        end
    end

    // ----------------------------------------
    // scan sequencer
    // ----------------------------------------
    lcr_pwm_if tm ();
    logic [8:0] slot;
    logic [5:0] sect;
    logic [LINE_W-1:0] cur_line;
    logic [8:0] slot_last;
    logic [5:0] sect_last;
    logic mode13;
    logic mult;

    // multiplier halves slot and doubles sections
    assign mode13 = cfg[IDX_CFG1][DEPTH_BIT];
    assign mult = cfg[IDX_CFG1][MULT_BIT];
    assign slot_last = mult ? SLOT_LAST_X2 : SLOT_LAST;
    // sections per period from depth and multiplier
    assign tm.shift_k = SHIFT_14 - {2'h0, mode13} + {2'h0, mult};
    assign sect_last = 6'((7'h1 << tm.shift_k) - 7'h1);
    assign tm.mode13 = mode13;
    assign tm.slot = slot;
    assign tm.sect = sect;

    // every line gets a slot in each section
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            slot <= '0;
            cur_line <= '0;
            sect <= '0;
        end else if (gtick) begin
            if (slot >= slot_last) begin
                slot <= '0;
                // count limited by the scan field
                if (cur_line >= scan_code) begin
                    cur_line <= '0;
                    sect <= (sect >= sect_last) ? '0 : sect + 6'h1;
                end else begin
                    cur_line <= cur_line + 5'h1;
                end
            end else begin
                slot <= slot + 9'h1;
            end
        end
    end

    // ----------------------------------------
    // channels
    // ----------------------------------------
    logic [CH_N-1:0] ch_on;

    for (genvar c = 0; c < CH_N; c++) begin : g_ch
        lcr_pwm_chan u_ch (
            .tm(tm.chan),
            .gray_word(gray_mem[cur_line][c]),
            .on(ch_on[c])
        );
    end

    // outputs tied to the current line
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            current_sink_outputs_b <= '1;
            scan_line <= '0;
        end else begin
            current_sink_outputs_b <= ~ch_on;
            scan_line <= cur_line;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    logic settled;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            settled <= 1'b0;
        end else begin
            settled <= 1'b1;
        end
    end

    sequence s_dark_write;
        cmd_go && cap_cnt == CMD_WR_BASE + 4'h1;
    endsequence

    sequence s_line_wrap;
        gtick && slot >= slot_last && cur_line >= scan_code;
    endsequence

    a_comp_reset_val: assert property (!settled |-> cfg[IDX_DARK] == COMP_RST && cfg[IDX_DISP] == COMP_RST)
        else $error("compensation registers not at reset value");
    a_detp_reset_val: assert property (!settled |-> cfg[IDX_DETP] == DETP_RST && cfg[IDX_SPARE] == SPARE_RST)
        else $error("fifth or sixth register not at reset value");
    a_scan_reset_val: assert property (!settled |-> scan_code == 5'h03 && !mode13 && !mult)
        else $error("first register fields not at reset value");
    a_commit_on_latch: assert property (!wr_hit |=> $stable(cfg[IDX_DARK]) && $stable(cfg[IDX_DETP]))
        else $error("configuration changed without a latch command");
    a_dark_write_lands: assert property (s_dark_write |=> cfg[IDX_DARK] == $past(cap_word))
        else $error("dark register write lost");
    a_gate_blocks_spare: assert property (!cfg[IDX_DETP][GATE_BIT] |=> sixth_register_gate_out == SPARE_RST)
        else $error("sixth register passed while gate is off");
    a_prech_zero_off: assert property (cfg[IDX_DETP][PRE_LSB +: LVL_W] == 5'h00 |=> !precharge_on)
        else $error("precharge on with zero level");
    a_stage_zero_off: assert property (cfg[IDX_DISP][LVL_HI +: LVL_W] == 5'h00 |=> !display_stage_on[2])
        else $error("display stage on with zero level");
    a_line_wraps: assert property (s_line_wrap |=> cur_line == 5'h00)
        else $error("scan line did not wrap at the scan code");
    a_zero_gray_dark: assert property (gray_mem[cur_line][0] == 16'h0000 |=> current_sink_outputs_b[0])
        else $error("channel lit with zero gray");
    a_latch_count_start: assert property (@(posedge shift_clock) disable iff (!rst_b)
        latch_strobe && !latch_d |=> cap_cnt == 4'h1)
        else $error("latch edge count did not restart");
endmodule : lcr_cfg_top
`default_nettype wire

// file: lcr_pkg.sv
// constants shared by the led driver configuration block
// assumes a 200 mhz system clock and a controller-driven serial link
`default_nettype none
package lcr_pkg;
    // ----------------------------------------
    // widths and sizes
    // ----------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam int unsigned CH_N = 16;
    localparam int unsigned MAX_LINES = 32;
    localparam int unsigned LINE_W = 5;
    localparam int unsigned REG_N = 5;
    localparam int unsigned CNT_W = 4;

    // ----------------------------------------
    // register indices and reset values
    // ----------------------------------------
    localparam logic [2:0] IDX_CFG1 = 3'h0;
    localparam logic [2:0] IDX_DARK = 3'h1;
    localparam logic [2:0] IDX_DISP = 3'h2;
    localparam logic [2:0] IDX_DETP = 3'h3;
    localparam logic [2:0] IDX_SPARE = 3'h4;
    localparam logic [15:0] CFG1_RST = 16'h033f;
    localparam logic [15:0] COMP_RST = 16'h7fff;
    localparam logic [15:0] DETP_RST = 16'h001f;
    localparam logic [15:0] SPARE_RST = 16'h0000;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int unsigned EN_BIT = 15;
    localparam int unsigned LVL_W = 5;
    localparam int unsigned LVL_HI = 10;
    localparam int unsigned LVL_MID = 5;
    localparam int unsigned LVL_LO = 0;
    localparam int unsigned GATE_BIT = 15;
    localparam int unsigned DET_LSB = 5;
    localparam int unsigned DET_W = 3;
    localparam int unsigned PRE_LSB = 0;
    localparam int unsigned SCAN_LSB = 8;
    localparam int unsigned DEPTH_BIT = 7;
    localparam int unsigned MULT_BIT = 6;

    // ----------------------------------------
    // latch commands: shift clock edges seen while latch is high
    // ----------------------------------------
    localparam logic [3:0] CMD_GRAY = 4'h1;
    localparam logic [3:0] CMD_WR_BASE = 4'h4;
    localparam logic [3:0] CMD_RD_BASE = 4'ha;
    localparam logic [3:0] CMD_SPAN = 4'h5;

    // ----------------------------------------
    // pwm timing in grayscale clocks
    // ----------------------------------------
    localparam logic [8:0] SLOT_LAST = 9'h1ff;
    localparam logic [8:0] SLOT_LAST_X2 = 9'h0ff;
    localparam logic [2:0] SHIFT_14 = 3'h5;
endpackage : lcr_pkg
`default_nettype wire

// file: lcr_pwm_if.sv
// slot timing shared from the scan sequencer to every channel
// assumes one sequencer drives it and channels only read it
`timescale 1ns/10ps
`default_nettype none
interface lcr_pwm_if;
    logic mode13;
    logic [2:0] shift_k;
    logic [8:0] slot;
    logic [5:0] sect;
    modport ctrl (output mode13, output shift_k, output slot, output sect);
    modport chan (input mode13, input shift_k, input slot, input sect);
endinterface : lcr_pwm_if
`default_nettype wire

// file: lcr_sync.sv
// two-flop level synchroniser
// assumes the input is a level from another clock or a pin
`timescale 1ns/10ps
`default_nettype none
module lcr_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : lcr_sync
`default_nettype wire

// file: lcr_pwm_chan.sv
// one output channel of the scrambled pwm
// assumes the gray word and slot timing are in the system clock domain
`timescale 1ns/10ps
`default_nettype none
module lcr_pwm_chan
    import lcr_pkg::*;
(
    // timing
    lcr_pwm_if.chan tm,
    // data
    input wire logic [15:0] gray_word,
    output logic on
);
    logic [13:0] gray;
    logic [13:0] base;
    logic [13:0] rem;
    logic [13:0] mask;
    logic extra;

    always_comb begin
        gray = tm.mode13 ? {1'b0, gray_word[15:3]} : gray_word[15:2];
        mask = (14'h1 << tm.shift_k) - 14'h1;
        base = gray >> tm.shift_k;
        rem = gray & mask;
        extra = {8'h0, tm.sect} < rem;
        on = {5'h0, tm.slot} < (base + {13'h0, extra});
    end
endmodule : lcr_pwm_chan
`default_nettype wire

// file: lcr_ctl_model.sv
// display controller model driving the serial link of the config block
// assumes the bench calls one task at a time; link clock stands still between frames
`timescale 1ns/10ps
`default_nettype none
module lcr_ctl_model (
    // serial link
    output logic shift_clock,
    output logic serial_data_in,
    output logic latch_strobe,
    input wire logic serial_data_out
);
    initial begin
        shift_clock = 1'b0;
        serial_data_in = 1'b0;
        latch_strobe = 1'b0;
    end

    // ----------------------------------------
    // link cycles, 12 ns per shift clock
    // ----------------------------------------
    // data and latch change only while the clock is low
    task automatic tick(input logic d, input logic le);
        serial_data_in = d;
        latch_strobe = le;
        #6 shift_clock = 1'b1;
        #6 shift_clock = 1'b0;
    endtask : tick

    // msb first, latch high over the last n rises
    task automatic frame(input logic [15:0] w, input int n);
        for (int b = 15; b >= 0; b--) tick(w[b], b == 0 && n > 0);
        for (int e = 1; e < n; e++) tick(~w[0], 1'b1);
        latch_strobe = 1'b0;
        serial_data_in = ~w[0];
        // low gap covers latch sync and commit
        #100;
    endtask : frame

    // read command, load edges, then sixteen bits out
    // the link clock stood still through the gap, so the word loads on the third edge;
    // a fourth edge would already shift bit 15 out
    task automatic fetch(input int n, output logic [15:0] w);
        frame(16'h0000, n);
        for (int e = 0; e < 3; e++) tick(e[0], 1'b0);
        for (int b = 15; b >= 0; b--) begin
            w[b] = serial_data_out;
            tick(b[0], 1'b0);
        end
    endtask : fetch
endmodule : lcr_ctl_model
`default_nettype wire

// file: lcr_cfg_top_tb.sv
// bench for the led driver configuration block
// assumes the controller model above and a free running 30 ns grayscale clock
`timescale 1ns/10ps
`default_nettype none
module lcr_cfg_top_tb
    import lcr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic grayscale_clock = 1'b0;
    wire logic shift_clock;
    wire logic serial_data_in;
    wire logic latch_strobe;
    wire logic serial_data_out;
    logic [CH_N-1:0] current_sink_outputs_b;
    logic [LINE_W-1:0] scan_line;
    logic [2:0] dark_stage_on;
    logic [2:0] display_stage_on;
    logic [14:0] dark_levels;
    logic [14:0] display_levels;
    logic [DET_W-1:0] open_detect_level;
    logic [LVL_W-1:0] precharge_level;
    logic precharge_on;
    logic [15:0] sixth_register_gate_out;
    int err_total = 0;
    int compares = 0;
    int ticks = 0;
    logic [15:0] rst_val [5] = '{16'h033f, 16'h7fff, 16'h7fff, 16'h001f, 16'h0000};

    lcr_cfg_top lcr_cfg_top_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .shift_clock(shift_clock),
        .serial_data_in(serial_data_in), .latch_strobe(latch_strobe),
        .serial_data_out(serial_data_out), .grayscale_clock(grayscale_clock),
        .current_sink_outputs_b(current_sink_outputs_b), .scan_line(scan_line),
        .dark_stage_on(dark_stage_on), .display_stage_on(display_stage_on),
        .dark_levels(dark_levels), .display_levels(display_levels),
        .open_detect_level(open_detect_level), .precharge_level(precharge_level),
        .precharge_on(precharge_on), .sixth_register_gate_out(sixth_register_gate_out)
    );
    lcr_ctl_model lcr_ctl_model_i (
        .shift_clock(shift_clock), .serial_data_in(serial_data_in),
        .latch_strobe(latch_strobe), .serial_data_out(serial_data_out)
    );

    // ----------------------------------------
    // clocks
    // ----------------------------------------
    always #2.5 clk_sys = ~clk_sys;
    // six system cycles per tick keeps the pin well below a quarter rate
    always begin
        repeat (3) @(posedge clk_sys);
        #1 grayscale_clock = ~grayscale_clock;
    end
    always @(posedge grayscale_clock) ticks++;

    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [2:0] idx, input logic [15:0] v);
        lcr_ctl_model_i.frame(v, CMD_WR_BASE + idx);
    endtask : wr

    task automatic rd(input logic [2:0] idx, input logic [15:0] exp);
        logic [15:0] w;
        lcr_ctl_model_i.fetch(CMD_RD_BASE + idx, w);
        check("readback", exp, w);
    endtask : rd

    // from the change to line 1 until line 0 returns
    task automatic scan(input int lines, input int per);
        int t0;
        int n;
        wait (scan_line === 5'h00);
        @(scan_line);
        t0 = ticks;
        n = 1;
        while (scan_line !== 5'h00) begin
            @(scan_line);
            n++;
        end
        check("line count", lines, n);
        check("slot ticks", per * (lines - 1), ticks - t0);
    endtask : scan

    // low cycles of every channel over one whole slot
    task automatic pwm_slot;
        int lo [CH_N];
        logic [LINE_W-1:0] s;
        foreach (lo[c]) lo[c] = 0;
        @(scan_line);
        #1;
        s = scan_line;
        while (scan_line === s) begin
            foreach (lo[c]) lo[c] += (current_sink_outputs_b[c] === 1'b0);
            @(posedge clk_sys);
            #1;
        end
        foreach (lo[c]) check("sink low cycles", 6 * c, lo[c]);
    endtask : pwm_slot

    task automatic report_and_stop;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        @(posedge clk_sys);
        #1;
        check("dark_levels", 16'h7fff, dark_levels);
        check("dark_stage_on", 16'h0000, dark_stage_on);
        check("precharge", 16'h003f, {precharge_on, precharge_level});
        check("detect", 16'h0000, open_detect_level);
        check("gate", 16'h0000, sixth_register_gate_out);
        for (int i = 0; i < 5; i++) rd(i, rst_val[i]);
        wr(IDX_DARK, 16'h8421);
        check("dark_stage_on", 16'h0007, dark_stage_on);
        check("dark_levels", 16'h0421, dark_levels);
        wr(IDX_DARK, 16'h8020);
        check("dark_stage_on", 16'h0002, dark_stage_on);
        wr(IDX_DISP, 16'h7c1f);
        check("display_stage_on", 16'h0000, display_stage_on);
        wr(IDX_DISP, 16'hfc00);
        check("display_stage_on", 16'h0004, display_stage_on);
        // shifted word without latch, then an unlisted count
        lcr_ctl_model_i.frame(16'h0000, 0);
        lcr_ctl_model_i.frame(16'h0000, 9);
        check("display_levels", 16'h7c00, display_levels);
        rd(IDX_DISP, 16'hfc00);
        wr(IDX_DETP, 16'h7fe0);
        check("detect", 16'h0007, open_detect_level);
        check("precharge", 16'h0000, {precharge_on, precharge_level});
        wr(IDX_SPARE, 16'ha5c3);
        check("gate", 16'h0000, sixth_register_gate_out);
        rd(IDX_DETP, 16'h7fe0);
        rd(IDX_SPARE, 16'ha5c3);
        wr(IDX_DETP, 16'h8001);
        check("gate", 16'ha5c3, sixth_register_gate_out);
        check("precharge", 16'h0021, {precharge_on, precharge_level});
        wr(IDX_CFG1, 16'h023f);
        scan(3, 512);
        wr(IDX_CFG1, 16'h02ff);
        rd(IDX_CFG1, 16'h02ff);
        scan(3, 256);
        wr(IDX_CFG1, 16'h013f);
        // two lines of sixteen words, 14-bit value 32*c padded with two zeros
        for (int k = 0; k < 2 * CH_N; k++) lcr_ctl_model_i.frame(16'((k % CH_N) << 7), CMD_GRAY);
        pwm_slot();
        // same words read as 13-bit value 16*c with three low zeros, 16 sections
        wr(IDX_CFG1, 16'h01bf);
        pwm_slot();
        report_and_stop();
    end

    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end
endmodule : lcr_cfg_top_tb
`default_nettype wire
